// ### logic/tsd_top.sv
/*
  Transport stream sync, de-randomiser, quality measures and the
  byte-wide output port with its byte clock and qualifiers.
  Assumes corrected bytes from a decoder on sys_clk at 40 MHz,
  a configuration word held steady by logic on the same clock,
  and a byte-address read port for the status registers.
*/
`include "tsd_regs.svh"
module tsd_top #(
  parameter int BYTE_DIV = `TSD_BYTE_DIV,
  parameter int BER_PKTS = `TSD_BER_PERIOD_PKTS
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input tsd_pkg::tsd_rs_s rs_in,
  input wire logic rs_valid,
  output logic rs_ready,
  input tsd_pkg::tsd_cfg_s cfg,
  input wire logic [7:0] reg_addr,
  output logic [7:0] reg_rdata,
  output logic stream_lock_out,
  output logic stream_byte_clock,
  output logic [7:0] stream_byte_bus,
  output logic stream_valid_out,
  output logic packet_start_out,
  output logic packet_error_out
);
  import tsd_pkg::*;

  localparam int HALF = BYTE_DIV / 2;

  tsd_top_s st;
  tsd_top_s next_st;
  logic take;
  logic [7:0] cur_pos;
  logic cur_sync;
  logic lock_next;
  logic inv_sync;
  logic in_data;
  logic descramble_sequence_adv;
  logic [7:0] mask;

  // (RL14) optional bit reversal of the byte
  function automatic logic [7:0] tsd_order(
    input logic [7:0] b,
    input logic lsb
  );
    logic [7:0] r;
    r = b;
    if (lsb) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = b[7 - i];
      end
    end
    return r;
  endfunction : tsd_order

  // one byte taken at the start of each byte period
  assign rs_ready = (st.div == 8'h00);
  assign take = rs_valid && rs_ready;

  // byte classification for the descrambler
  always_comb begin
    inv_sync = cur_sync && (rs_in.data == `TSD_SYNC_INV);
    in_data = cur_pos < `TSD_DATA_LEN;
    descramble_sequence_adv = cur_sync ? 1'b1 : in_data;
  end

  tsd_sync u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .take(take),
    .byte_in(rs_in.data),
    .sync_n(cfg.sync_n),
    .loss_immediate(cfg.loss_immediate),
    .cur_pos(cur_pos),
    .cur_sync(cur_sync),
    .lock_next(lock_next),
    .locked()
  );

  tsd_descramble_sequence u_descramble_sequence (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .take(take),
    .reload(inv_sync),
    .advance(descramble_sequence_adv),
    .mask(mask)
  );

  // byte path, qualifiers, clock and measures
  always_comb begin
    logic [7:0] shown;
    logic pkt_err;
    logic err_on;
    logic second;
    logic [23:0] ber_sum;
    shown = 8'h00;
    pkt_err = 1'b0;
    err_on = 1'b0;
    second = 1'b0;
    ber_sum = st.ber_acc + {20'h0_0000, rs_in.fixed_bits};
    next_st = st;
    next_st.div = (st.div == 8'(BYTE_DIV - 1)) ? 8'h00
                                               : st.div + 8'h01;
    next_st.lock = lock_next;
    if (take) begin
      // (RL9) port opens at a packet start after lock
      if (cur_sync) begin
        next_st.emit = lock_next;
        next_st.err_pkt = rs_in.uncorr;
      end else if (!lock_next) begin
        next_st.emit = 1'b0;
      end
      next_st.pos = cur_pos;
      // (RL5) sync positions bypass the mask
      if (cur_sync) begin
        // (RL6) inverted sync leaves as plain sync
        // (RL10) packet opens with the sync code
        shown = `TSD_SYNC_BYTE;
      // (RL4) data bytes take the mask
      end else if (in_data) begin
        shown = rs_in.data ^ mask;
      end else begin
        shown = rs_in.data;
      end
      next_st.data = next_st.emit ? tsd_order(shown, cfg.bit_lsb_first)
                                  : 8'h00;
      // (RL12) whole packet clock
      // (RL13) data only clock
      next_st.act = next_st.emit && (!cfg.clk_data_only || in_data);
      // (RL15) data only valid
      // (RL16) pulsed valid
      next_st.valid = next_st.emit
                      && (cfg.valid_pulsed ? cur_sync : in_data);
      // (RL17) start flag on the sync byte
      next_st.start = next_st.emit && cur_sync;
      // (RL18) error only for uncorrectable packets
      pkt_err = cur_sync ? rs_in.uncorr : st.err_pkt;
      // (RL19) three error output shapes
      unique case (cfg.err_mode)
        TSD_ERR_WHOLE: err_on = pkt_err;
        TSD_ERR_DATA: err_on = pkt_err && in_data;
        TSD_ERR_PULSE: err_on = pkt_err && cur_sync;
        default: err_on = 1'b0;
      endcase
      next_st.err = next_st.emit && err_on;
    end else if (st.div == 8'h00) begin
      next_st.act = 1'b0;
      next_st.valid = 1'b0;
      next_st.start = 1'b0;
      next_st.err = 1'b0;
    end
    // (RL8) clock phase picks the sampling edge
    // (RL23) edge in mid byte, data held all period
    second = (next_st.div == 8'h00) || (next_st.div > 8'(HALF));
    next_st.clk = next_st.act && (second ^ cfg.clk_sample_fall);
    // (RL7) pre correction bit errors per period
    if (take && lock_next) begin
      next_st.ber_acc = ber_sum;
      if (cur_sync) begin
        if (st.pkt_cnt == 16'(BER_PKTS - 1)) begin
          next_st.bit_error_estimate = ber_sum;
          next_st.ber_acc = 24'h00_0000;
          next_st.pkt_cnt = 16'h0000;
        end else begin
          next_st.pkt_cnt = st.pkt_cnt + 16'h0001;
        end
        // (RL22) uncorrectable packets counted
        if (rs_in.uncorr && st.uncorr_cnt != 16'hFFFF) begin
          next_st.uncorr_cnt = st.uncorr_cnt + 16'h0001;
        end
        // (RL7) long term quality leaky count
        if (rs_in.uncorr) begin
          next_st.ltq_acc = (st.ltq_acc > 8'hFF - `TSD_LTQ_STEP)
                            ? 8'hFF : st.ltq_acc + `TSD_LTQ_STEP;
        end else if (st.ltq_acc != 8'h00) begin
          next_st.ltq_acc = st.ltq_acc - 8'h01;
        end
        next_st.q_poor = next_st.ltq_acc > `TSD_LTQ_THRESH;
      end
    end
    // (RL7) status read port
    unique case (reg_addr)
      `TSD_REG_FEC_LOCK_STATUS: begin
        next_st.rdata = 8'h00;
        next_st.rdata[`TSD_STAT_LOCK_BIT] = st.lock;
        next_st.rdata[`TSD_STAT_QPOOR_BIT] = st.q_poor;
      end
      `TSD_REG_BIT_ERROR_EST: next_st.rdata = st.bit_error_estimate[23:16];
      `TSD_REG_BIT_ERROR_EST + 8'h01: next_st.rdata = st.bit_error_estimate[15:8];
      `TSD_REG_BIT_ERROR_EST + 8'h02: next_st.rdata = st.bit_error_estimate[7:0];
      `TSD_REG_UNCORR_COUNT: next_st.rdata = st.uncorr_cnt[15:8];
      `TSD_REG_UNCORR_COUNT + 8'h01: next_st.rdata = st.uncorr_cnt[7:0];
      default: next_st.rdata = 8'h00;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
      st.q_poor <= 1'b1;
      st.rdata <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  // outputs, with per-signal polarity on lock, valid, start and error
  // (RL11) individual polarity controls
  always_comb begin
    reg_rdata = st.rdata;
    stream_byte_bus = st.data;
    stream_byte_clock = st.clk;
    stream_lock_out = st.lock ~^ cfg.pol_lock;
    stream_valid_out = st.valid ~^ cfg.pol_valid;
    packet_start_out = st.start ~^ cfg.pol_sync;
    packet_error_out = st.err ~^ cfg.pol_err;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_dark_unlocked;
    !st.emit |-> !st.act && !st.valid && !st.start && !st.err;
  endproperty
  a_dark_unlocked: assert property (p_dark_unlocked) // RL9
    else $error("port active while not emitting");

  property p_emit_locked;
    st.emit |-> st.lock;
  endproperty
  a_emit_locked: assert property (p_emit_locked) // RL9
    else $error("port emitting without stream lock");

  property p_start_code;
    st.start && !cfg.bit_lsb_first |-> st.data == `TSD_SYNC_BYTE;
  endproperty
  a_start_code: assert property (p_start_code) // RL10
    else $error("packet start byte is not the sync code");

  property p_clk_parity_quiet;
    st.act && cfg.clk_data_only |-> st.pos < `TSD_DATA_LEN;
  endproperty
  a_clk_parity_quiet: assert property (p_clk_parity_quiet) // RL13
    else $error("byte clock ran on a parity byte");

  property p_clk_whole;
    take && lock_next && (next_st.emit) && !cfg.clk_data_only
      |=> st.act;
  endproperty
  a_clk_whole: assert property (p_clk_whole) // RL12
    else $error("whole packet clock missed a byte");

  property p_rise_mid;
    $rose(st.clk) && !cfg.clk_sample_fall |-> st.div == 8'(HALF + 1);
  endproperty
  a_rise_mid: assert property (p_rise_mid) // RL8
    else $error("rising edge not in mid byte");

  property p_valid_shape;
    st.valid |-> (cfg.valid_pulsed ? st.pos == 8'h00
                                   : st.pos < `TSD_DATA_LEN);
  endproperty
  a_valid_shape: assert property (p_valid_shape) // RL15
    else $error("valid outside its window");

  property p_pulse_valid;
    cfg.valid_pulsed && st.valid |-> st.start;
  endproperty
  a_pulse_valid: assert property (p_pulse_valid) // RL16
    else $error("pulsed valid away from sync byte");

  property p_start_sync;
    st.start |-> st.pos == 8'h00 && st.emit;
  endproperty
  a_start_sync: assert property (p_start_sync) // RL17
    else $error("packet start away from sync byte");

  property p_err_cause;
    st.err |-> st.err_pkt;
  endproperty
  a_err_cause: assert property (p_err_cause) // RL18
    else $error("error output on a good packet");

  property p_err_pulse;
    st.err && cfg.err_mode == TSD_ERR_PULSE |-> st.pos == 8'h00;
  endproperty
  a_err_pulse: assert property (p_err_pulse) // RL19
    else $error("pulsed error away from sync byte");

  property p_byte_pace;
    take |=> !rs_ready [*7];
  endproperty
  a_byte_pace: assert property (p_byte_pace) // RL23
    else $error("more than one byte per byte period");

  property p_data_hold;
    st.div != 8'h00 |=> $stable(st.data);
  endproperty
  a_data_hold: assert property (p_data_hold) // RL23
    else $error("output byte changed inside its period");

  c_lock: cover property (!st.lock ##1 st.lock);
  c_inv_sync: cover property (take && inv_sync && st.emit);
  c_err_pkt: cover property (st.err && st.start);
  c_parity_quiet: cover property (st.emit && !st.act && st.div == 8'h03);

endmodule : tsd_top

// ### logic/tsd_regs.svh
/*
  Constants of the stream sync, de-randomiser and output port block:
  register offsets, fields, reset values, byte codes and timing counts.
  Assumes inclusion by bare name from the design modules and the test bench.
*/
// Notes on behaviour
// (RL1) lock after n consecutive sync bytes, n 2..7
// (RL2) immediate mode: one missed sync drops lock
// (RL3) filtered mode: count down, drop at zero
// (RL4) descramble with 15-stage sequence, fixed seed
// (RL5) sync byte positions pass unscrambled
// (RL6) inverted sync reloads seed, re-inverted on output
// (RL7) pre and post correction error measures readable
// (RL8) byte clock edge selectable rising or falling
// (RL9) output port dark until stream lock
// (RL10) packet opens with 47h, data, parity
// (RL11) each control output has own polarity
// (RL12) whole packet clock: all 204 bytes
// (RL13) data only clock: 188 bytes, parity silent
// (RL14) bit order selectable, default bit 7 MSB
// (RL15) data only valid: 188 active, 16 inactive
// (RL16) pulsed valid: active on sync byte only
// (RL17) packet start active on sync byte only
// (RL18) error output only for uncorrectable packets
// (RL19) error output: whole, data only, pulsed
// (RL20) receiver uses valid to skip parity bytes
// (RL21) receiver uses valid as clock enable
// (RL22) decoder flags packets beyond 8 bad bytes
// (RL23) one byte per clock period, held stable
`ifndef TSD_REGS_SVH
`define TSD_REGS_SVH

`define TSD_REG_FEC_LOCK_STATUS 8'h05
`define TSD_REG_BIT_ERROR_EST 8'h0B
`define TSD_REG_UNCORR_COUNT 8'h0E
`define TSD_FEC_LOCK_STATUS_RST 8'h10
`define TSD_STAT_LOCK_BIT 0
`define TSD_STAT_QPOOR_BIT 4

`define TSD_SYNC_BYTE 8'h47
`define TSD_SYNC_INV 8'hB8
`define TSD_PKT_LAST 8'hCB
`define TSD_DATA_LEN 8'hBC
`define TSD_DESCRAMBLE_SEQUENCE_INIT 15'h00A9

`define TSD_LTQ_THRESH 8'h04
`define TSD_LTQ_STEP 8'h04
`define TSD_BER_PERIOD_PKTS 16'h03E8

`define TSD_CLK_PERIOD_NS 25
`define TSD_BYTE_PERIOD_NS 200
`define TSD_BYTE_DIV (`TSD_BYTE_PERIOD_NS / `TSD_CLK_PERIOD_NS)

`endif

// ### logic/tsd_pkg.sv
/*
  Types of the stream sync, de-randomiser and output port block.
  Assumes nothing of its surroundings.
*/
package tsd_pkg;

  typedef enum logic [1:0] {
    TSD_ERR_WHOLE, TSD_ERR_DATA, TSD_ERR_PULSE
  } tsd_err_mode_e;

  // one corrected byte from the error decoder
  typedef struct packed {
    logic [7:0] data;
    logic uncorr;
    logic [3:0] fixed_bits;
  } tsd_rs_s;

  typedef struct packed {
    logic [2:0] sync_n;
    logic loss_immediate;
    logic clk_data_only;
    logic clk_sample_fall;
    logic bit_lsb_first;
    logic valid_pulsed;
    tsd_err_mode_e err_mode;
    logic pol_lock;
    logic pol_valid;
    logic pol_sync;
    logic pol_err;
  } tsd_cfg_s;

  typedef struct packed {
    logic [2:0] cnt;
    logic [7:0] pos;
    logic locked;
  } tsd_sync_s;

  typedef struct packed {
    logic [14:0] sr;
  } tsd_descramble_sequence_s;

  typedef struct packed {
    logic [7:0] div;
    logic act;
    logic emit;
    logic [7:0] pos;
    logic err_pkt;
    logic [7:0] data;
    logic clk;
    logic valid;
    logic start;
    logic err;
    logic lock;
    logic [23:0] ber_acc;
    logic [23:0] bit_error_estimate;
    logic [15:0] pkt_cnt;
    logic [15:0] uncorr_cnt;
    logic [7:0] ltq_acc;
    logic q_poor;
    logic [7:0] rdata;
  } tsd_top_s;

endpackage : tsd_pkg

// ### logic/tsd_descramble_sequence.sv
/*
  Energy dispersal sequence generator, eight bits per byte.
  Assumes take, reload and advance come from logic on sys_clk.
*/
`include "tsd_regs.svh"
module tsd_descramble_sequence (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic take,
  input wire logic reload,
  input wire logic advance,
  output logic [7:0] mask
);
  import tsd_pkg::*;

  tsd_descramble_sequence_s st;
  tsd_descramble_sequence_s next_st;

  // (RL4) eight steps of 1 + x14 + x15
  always_comb begin
    logic [14:0] sr;
    logic fb;
    sr = st.sr;
    fb = 1'b0;
    mask = 8'h00;
    for (int i = 0; i < 8; i++) begin
      fb = sr[13] ^ sr[14];
      mask[7 - i] = fb;
      sr = {sr[13:0], fb};
    end
    next_st = st;
    if (take && reload) begin
      next_st.sr = `TSD_DESCRAMBLE_SEQUENCE_INIT;
    end else if (take && advance) begin
      next_st.sr = sr;
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st.sr <= `TSD_DESCRAMBLE_SEQUENCE_INIT;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_descramble_sequence_reload;
    take && reload |=> st.sr == `TSD_DESCRAMBLE_SEQUENCE_INIT;
  endproperty
  a_descramble_sequence_reload: assert property (p_descramble_sequence_reload) // RL6
    else $error("sequence not reloaded on inverted sync");

  property p_descramble_sequence_hold;
    !take || (!reload && !advance) |=> $stable(st.sr);
  endproperty
  a_descramble_sequence_hold: assert property (p_descramble_sequence_hold) // RL5
    else $error("sequence moved without an advance");

endmodule : tsd_descramble_sequence

// ### logic/tsd_sync.sv
/*
  Sync byte hunt, verify and lock tracker with packet position.
  Assumes one take pulse per byte from logic on sys_clk.
*/
`include "tsd_regs.svh"
module tsd_sync (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic take,
  input wire logic [7:0] byte_in,
  input wire logic [2:0] sync_n,
  input wire logic loss_immediate,
  output logic [7:0] cur_pos,
  output logic cur_sync,
  output logic lock_next,
  output logic locked
);
  import tsd_pkg::*;

  tsd_sync_s st;
  tsd_sync_s next_st;
  logic hit;
  logic aligned;
  logic [2:0] n_eff;

  // hunt, count hits, track losses
  always_comb begin
    n_eff = (sync_n < 3'h2) ? 3'h2 : sync_n;
    hit = (byte_in == `TSD_SYNC_BYTE) || (byte_in == `TSD_SYNC_INV);
    aligned = (st.cnt != 3'h0) || st.locked;
    cur_pos = aligned ? st.pos : 8'h00;
    cur_sync = aligned ? (st.pos == 8'h00) : hit;
    next_st = st;
    if (take && !aligned && hit) begin
      next_st.cnt = 3'h1;
      next_st.pos = 8'h01;
    end else if (take && aligned) begin
      next_st.pos = (st.pos == `TSD_PKT_LAST) ? 8'h00 : st.pos + 8'h01;
      if (st.pos == 8'h00) begin
        if (hit && st.locked) begin
          next_st.cnt = n_eff;
        // (RL1) lock on the n-th hit
        end else if (hit && (st.cnt + 3'h1 >= n_eff)) begin
          next_st.cnt = n_eff;
          next_st.locked = 1'b1;
        end else if (hit) begin
          next_st.cnt = st.cnt + 3'h1;
        // (RL3) filtered loss counts down
        end else if (st.locked && !loss_immediate && st.cnt > 3'h1) begin
          next_st.cnt = st.cnt - 3'h1;
        // (RL2) drop lock, back to hunting
        end else begin
          next_st.cnt = 3'h0;
          next_st.locked = 1'b0;
          next_st.pos = 8'h00;
        end
      end
    end
    lock_next = next_st.locked;
    locked = st.locked;
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_lock_count;
    !st.locked ##1 st.locked |-> $past(st.cnt) == n_eff - 3'h1;
  endproperty
  a_lock_count: assert property (p_lock_count) // RL1
    else $error("lock taken before n sync hits");

  property p_drop_now;
    st.locked && take && cur_sync && !hit && loss_immediate
      |=> !st.locked;
  endproperty
  a_drop_now: assert property (p_drop_now) // RL2
    else $error("immediate mode kept lock after a miss");

  property p_filter_down;
    st.locked && take && cur_sync && !hit && !loss_immediate
      && st.cnt > 3'h1 |=> st.locked && st.cnt == $past(st.cnt) - 3'h1;
  endproperty
  a_filter_down: assert property (p_filter_down) // RL3
    else $error("filtered mode did not count down by one");

endmodule : tsd_sync

// ### sim/tsd_demux_model.sv
/*
  Receiving demultiplexer model for the stream output port: it finds
  the sampling edge of the byte clock and records each byte taken.
  Assumes the port outputs and the config word are on sys_clk.
*/
module tsd_demux_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input tsd_pkg::tsd_cfg_s cfg,
  input wire logic stream_byte_clock,
  input wire logic [7:0] stream_byte_bus,
  input wire logic stream_valid_out,
  input wire logic packet_start_out,
  input wire logic packet_error_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import tsd_pkg::*;

  logic prev_clk;
  logic hit;
  logic [10:0] rec [$]; // byte, valid, start, error as active levels
  int n_data; // bytes captured with valid used as enable

  // sampling edge follows the configured clock sense
  // edge select
  assign hit = cfg.clk_sample_fall ? (prev_clk & ~stream_byte_clock)
                                   : (~prev_clk & stream_byte_clock);

  // one record per sampling edge; valid kept so parity can be skipped
  // qualifier levels
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      rec.delete();
      n_data <= 0;
    end else if (hit) begin
      rec.push_back({stream_byte_bus, stream_valid_out == cfg.pol_valid,
                     packet_start_out == cfg.pol_sync,
                     packet_error_out == cfg.pol_err});
      // valid gates the data count when not pulsed, parity bytes skipped
      if (!cfg.valid_pulsed && stream_valid_out == cfg.pol_valid) begin
        n_data <= n_data + 1;
      end
    end
    prev_clk <= stream_byte_clock;
  end
endmodule : tsd_demux_model

// ### sim/tsd_top_test.sv
/*
  Self-checking bench of the stream sync, de-randomiser and output
  port: feeds scrambled packets, predicts the port, reads registers.
  Assumes the design files and the demultiplexer model are compiled.
*/
`include "tsd_regs.svh"
`define CHECK(nm, ex, got) \
  begin \
    check_count++; \
    if ((got) !== (ex)) begin \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
      n_errors++; \
    end \
  end
module tsd_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import tsd_pkg::*;

  logic sys_clk, rst_n, rs_valid, rs_ready;
  tsd_rs_s rs_in;
  tsd_cfg_s cfg;
  logic [7:0] reg_addr, reg_rdata, stream_byte_bus;
  logic stream_lock_out, stream_byte_clock, stream_valid_out;
  logic packet_start_out, packet_error_out;
  int n_errors, check_count;
  logic [14:0] sr; // reference de-randomiser state
  logic emit;
  logic [10:0] exp_q [$];

  tsd_top #(.BYTE_DIV(8), .BER_PKTS(4)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .rs_in(rs_in),
    .rs_valid(rs_valid), .rs_ready(rs_ready), .cfg(cfg),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .stream_lock_out(stream_lock_out),
    .stream_byte_clock(stream_byte_clock),
    .stream_byte_bus(stream_byte_bus),
    .stream_valid_out(stream_valid_out),
    .packet_start_out(packet_start_out),
    .packet_error_out(packet_error_out)
  );

  tsd_demux_model demux_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .cfg(cfg),
    .stream_byte_clock(stream_byte_clock),
    .stream_byte_bus(stream_byte_bus),
    .stream_valid_out(stream_valid_out),
    .packet_start_out(packet_start_out),
    .packet_error_out(packet_error_out)
  );

  // 40 MHz system clock
  always #12.5 sys_clk = ~sys_clk;

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  // eight sequence bits, first one lands on byte bit 7
  task automatic adv8(output logic [7:0] m);
    logic fb;
    for (int k = 7; k >= 0; k--) begin
      fb = sr[13] ^ sr[14];
      sr = {sr[13:0], fb};
      m[k] = fb;
    end
  endtask : adv8

  task automatic do_reset();
    rst_n = 1'b0;
    rs_valid = 1'b0;
    repeat (12) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    @(posedge sys_clk);
    #1;
  endtask : do_reset

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    @(posedge sys_clk);
    #1 d = reg_rdata;
  endtask : rd

  // hold the byte until an edge sees ready high
  task automatic send_byte(input logic [7:0] b, input logic u,
                           input logic [3:0] f);
    int k;
    k = 0;
    rs_in = '{data: b, uncorr: u, fixed_bits: f};
    rs_valid = 1'b1;
    while (rs_ready !== 1'b1) begin
      @(posedge sys_clk);
      #1 k++;
      if (k > 20) begin
        $display("CHECK FAILED ready expected 1 seen 0");
        n_errors++;
        conclude();
      end
    end
    @(posedge sys_clk);
    #1;
  endtask : send_byte

  // one packet, scrambled as sent, with the port's expected records
  task automatic send_packet(input int i, input bit miss);
    logic [7:0] pl, b, m, r;
    logic u, e;
    int nn;
    nn = int'(cfg.sync_n);
    u = (i == 2 || i == 4);
    for (int p = 0; p < 204; p++) begin
      pl = 8'($urandom);
      if (p == 0) begin
        pl = `TSD_SYNC_BYTE;
        b = pl;
        if (i >= nn - 1 && (i - nn + 1) % 8 == 0) begin
          b = `TSD_SYNC_INV;
          sr = `TSD_DESCRAMBLE_SEQUENCE_INIT;
        end else begin
          adv8(m);
        end
        if (miss) b = 8'h00;
      end else if (p < 188) begin
        adv8(m);
        b = pl ^ m;
      end else begin
        b = pl;
      end
      send_byte(b, u, (p == 5) ? 4'h3 : 4'h0);
      r = {<<{pl}};
      e = u && (cfg.err_mode == TSD_ERR_WHOLE ||
                (cfg.err_mode == TSD_ERR_DATA && p < 188) ||
                (cfg.err_mode == TSD_ERR_PULSE && p == 0));
      if (emit && (!cfg.clk_data_only || p < 188)) begin
        exp_q.push_back({cfg.bit_lsb_first ? r : pl,
                         cfg.valid_pulsed ? p == 0 : p < 188, p == 0, e});
      end
    end
  endtask : send_packet

  // one output mode set: lock, port stream, registers
  task automatic run_stream(input int t);
    logic [7:0] d;
    int npk;
    int nv;
    npk = (t == 0) ? 10 : 3;
    cfg = '0;
    cfg.sync_n = 3'd2;
    {cfg.pol_lock, cfg.pol_valid, cfg.pol_sync, cfg.pol_err} = 4'hF;
    case (t)
      1: begin
        {cfg.clk_data_only, cfg.valid_pulsed, cfg.clk_sample_fall} = 3'h7;
        cfg.bit_lsb_first = 1'b1;
        cfg.err_mode = TSD_ERR_DATA;
        {cfg.pol_lock, cfg.pol_valid, cfg.pol_sync, cfg.pol_err} = 4'h0;
      end
      2: begin
        cfg.bit_lsb_first = 1'b1;
        cfg.err_mode = TSD_ERR_PULSE;
        {cfg.pol_valid, cfg.pol_err} = 2'h0;
      end
      3: begin
        cfg.clk_data_only = 1'b1;
        cfg.err_mode = tsd_err_mode_e'(2'd3);
        {cfg.pol_lock, cfg.pol_sync} = 2'h0;
      end
      default: ;
    endcase
    do_reset();
    `CHECK("lock idle", ~cfg.pol_lock, stream_lock_out)
    rd(8'h05, d);
    `CHECK("status reset", `TSD_FEC_LOCK_STATUS_RST, d)
    rd(8'h21, d);
    `CHECK("unmapped", 8'h00, d)
    for (int i = 0; i < npk; i++) begin
      emit = (i >= 1);
      send_packet(i, 1'b0);
    end
    rs_valid = 1'b0;
    repeat (20) @(posedge sys_clk);
    #1 `CHECK("lock", cfg.pol_lock, stream_lock_out)
    nv = cfg.valid_pulsed ? 0 : (npk - 1) * 188;
    `CHECK("valid bytes", nv, demux_u.n_data)
    `CHECK("bytes", exp_q.size(), demux_u.rec.size())
    for (int j = 0; j < exp_q.size() && j < demux_u.rec.size(); j++) begin
      `CHECK("port", exp_q[j], demux_u.rec[j]) // 19
    end
    if (t == 0) begin
      rd(8'h0D, d);
      `CHECK("error estimate", 8'h0C, d)
      rd(8'h0C, d);
      `CHECK("error estimate mid", 8'h00, d)
      rd(8'h0F, d);
      `CHECK("uncorrectable", 8'h02, d)
      rd(8'h05, d);
      `CHECK("status locked", 8'h01, d)
    end
    exp_q.delete();
    $display("stream test %0d done", t);
  endtask : run_stream

  // missed syncs after lock: miss, hit, miss, miss, miss
  task automatic run_loss(input logic imm);
    int cnt, c;
    logic lk;
    logic [4:0] pat;
    cfg = '0;
    cfg.sync_n = 3'd3;
    cfg.loss_immediate = imm;
    {cfg.pol_lock, cfg.pol_valid, cfg.pol_sync, cfg.pol_err} = 4'hF;
    do_reset();
    emit = 1'b0;
    pat = 5'b11101;
    for (int i = 0; i < 3; i++) begin
      send_packet(i, 1'b0);
      `CHECK("early lock", i == 2, stream_lock_out)
    end
    cnt = 3;
    lk = 1'b1;
    for (int j = 0; j < 5 && lk; j++) begin
      send_packet(3 + j, pat[j]);
      if (!pat[j]) cnt = 3;
      else if (imm || cnt <= 1) lk = 1'b0;
      else cnt--;
      `CHECK("lock loss", lk, stream_lock_out)
    end
    c = demux_u.rec.size();
    `CHECK("shown", 1'b1, c > 0)
    send_packet(9, 1'b0);
    rs_valid = 1'b0;
    repeat (20) @(posedge sys_clk);
    #1 `CHECK("dark", c, demux_u.rec.size())
    $display("loss test %0d done", imm);
  endtask : run_loss

  // main sequence
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    rs_valid = 1'b0;
    rs_in = '0;
    reg_addr = 8'h00;
    cfg = '0;
    n_errors = 0;
    check_count = 0;
    sr = `TSD_DESCRAMBLE_SEQUENCE_INIT;
    emit = 1'b0;
    void'($urandom(85));
    for (int t = 0; t < 4; t++) run_stream(t);
    run_loss(1'b0);
    run_loss(1'b1);
    conclude();
  end
endmodule : tsd_top_test
